/* File: ddc_decoder.sv */
// command and clock-enable decoder for a four-bank ddr dram
`timescale 1ns/10ps
module ddc_decoder #(
  parameter int LANES = 2,
  parameter int BURST_CYC = 4,
  parameter logic [1:0] WIDTH_SEL = ddc_pkg::WIDTH_X16
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // link clock and command pins from the controller
  input wire logic link_clk_i,
  input wire logic clk_en_i,
  input wire logic chip_sel_n_i,
  input wire logic row_strobe_n_i,
  input wire logic col_strobe_n_i,
  input wire logic write_en_n_i,
  input wire logic [ddc_pkg::BANK_W-1:0] bank_i,
  input wire logic [ddc_pkg::ADDR_W-1:0] addr_i,
  // write masks per lane (lower_byte_mask is bit 0, upper_byte_mask bit 1)
  input wire logic [LANES-1:0] byte_mask_i,
  // decoded command
  output logic cmd_valid_o,
  output logic [3:0] cmd_o,
  output logic [ddc_pkg::BANK_W-1:0] cmd_bank_o,
  output logic [ddc_pkg::ADDR_W-1:0] row_o,
  output logic [ddc_pkg::ADDR_W-1:0] col_o,
  output logic auto_pre_o,
  // mode registers
  output logic [ddc_pkg::ADDR_W-1:0] mode_reg_o,
  output logic [ddc_pkg::ADDR_W-1:0] ext_mode_reg_o,
  // bank and power status
  output logic [ddc_pkg::NUM_BANKS-1:0] bank_open_o,
  output logic [3:0] pwr_state_o,
  output logic exit_busy_o,
  // refresh counters
  output logic [ddc_pkg::BANK_W-1:0] ref_bank_o,
  output logic [ddc_pkg::ADDR_W-1:0] ref_row_o,
  // data lanes
  output logic [LANES-1:0] byte_we_o,
  output logic [LANES-1:0] strobe_oe_n_o
);

  localparam int PIN_W = 5 + ddc_pkg::BANK_W + ddc_pkg::ADDR_W;
  localparam int BC_W = $clog2(BURST_CYC + 1);
  localparam int EX_W = $clog2(ddc_pkg::SELF_REFRESH_EXIT_CYC + 1);

  // synchronised pins
  logic link_clk_s;
  logic [PIN_W-1:0] pins_s;
  logic [LANES-1:0] mask_s;
  // previous link clock level for edge detect
  logic link_clk_q_r;
  logic link_rise;
  // captured command pins
  logic cke_now;
  logic cs_n;
  logic [2:0] enc;
  logic [ddc_pkg::BANK_W-1:0] bank_s;
  logic [ddc_pkg::ADDR_W-1:0] addr_s;
  // clock enable at previous link edge
  logic cke_prev_r;
  // power state machine
  // nothing is imported, so the state type carries its package name
  ddc_pkg::ddc_pwr_e pwr_r;
  ddc_pkg::ddc_pwr_e pwr_nxt;
  // decoded command for this edge
  ddc_pkg::ddc_cmd_e cmd_nxt;
  logic all_idle;
  logic ap_bit;
  // burst tracking
  logic [BC_W-1:0] burst_cnt_r;
  logic burst_wr_r;
  // self refresh exit counter
  logic [EX_W-1:0] exit_cnt_r;

  // column address gathering by part width
  function automatic logic [ddc_pkg::ADDR_W-1:0] col_of(input logic [ddc_pkg::ADDR_W-1:0] a);
    logic [ddc_pkg::ADDR_W-1:0] c;
    c = '0;
    case (WIDTH_SEL)
      ddc_pkg::WIDTH_X32: c = {4'h0, a[ddc_pkg::COL_A9], a[7:0]};
      ddc_pkg::WIDTH_X8: c = {2'h0, a[ddc_pkg::COL_HI_X8], a[9:0]};
      default: c = {3'h0, a[9:0]};
    endcase
    return c;
  endfunction : col_of

  // pin synchronisers
  ddc_sync #(.W(1), .INIT(1'b0)) u_clk_sync (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .d_i(link_clk_i),
    .q_o(link_clk_s)
  );

  ddc_sync #(.W(PIN_W), .INIT({1'b0, 4'hf, {(PIN_W-5){1'b0}}})) u_pin_sync (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .d_i({clk_en_i, chip_sel_n_i, row_strobe_n_i, col_strobe_n_i, write_en_n_i,
          bank_i, addr_i}),
    .q_o(pins_s)
  );

  ddc_sync #(.W(LANES), .INIT('1)) u_mask_sync (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .d_i(byte_mask_i),
    .q_o(mask_s)
  );

  // unpack filtered pins
  assign cke_now = pins_s[PIN_W-1];
  assign cs_n = pins_s[PIN_W-2];
  assign enc = pins_s[PIN_W-3 -: 3];
  assign bank_s = pins_s[ddc_pkg::ADDR_W +: ddc_pkg::BANK_W];
  assign addr_s = pins_s[ddc_pkg::ADDR_W-1:0];
  assign all_idle = (bank_open_o == '0);
  assign ap_bit = (WIDTH_SEL == ddc_pkg::WIDTH_X32) ? addr_s[ddc_pkg::AP_BIT_X32]
                                                    : addr_s[ddc_pkg::AP_BIT_X16];

  // link clock edge detect
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      link_clk_q_r <= 1'b0;
    end else begin
      link_clk_q_r <= link_clk_s;
    end
  end

  assign link_rise = link_clk_s & ~link_clk_q_r;

  // command and power decode for the current link edge
  always_comb begin
    cmd_nxt = ddc_pkg::DDC_CMD_NOP;
    pwr_nxt = pwr_r;
    case (pwr_r)
      // normal operation: full command decode
      ddc_pkg::DDC_PS_RUN: begin
        if (cs_n) begin
          cmd_nxt = ddc_pkg::DDC_CMD_NOP;
        end else begin
          case (enc)
            ddc_pkg::ENC_ACT: cmd_nxt = ddc_pkg::DDC_CMD_ACT;
            ddc_pkg::ENC_RD: cmd_nxt = ddc_pkg::DDC_CMD_RD;
            ddc_pkg::ENC_WR: cmd_nxt = ddc_pkg::DDC_CMD_WR;
            ddc_pkg::ENC_BST: cmd_nxt = ddc_pkg::DDC_CMD_BST;
            ddc_pkg::ENC_PRE: begin
              cmd_nxt = ap_bit ? ddc_pkg::DDC_CMD_PREALL : ddc_pkg::DDC_CMD_PRE;
            end
            ddc_pkg::ENC_REF: begin
              cmd_nxt = ddc_pkg::DDC_CMD_REF;
            end
            ddc_pkg::ENC_MRS: begin
              cmd_nxt = (bank_s == ddc_pkg::MR_BASE_SEL) ? ddc_pkg::DDC_CMD_MRS
                                                          : ddc_pkg::DDC_CMD_EMRS;
            end
            default: cmd_nxt = ddc_pkg::DDC_CMD_NOP;
          endcase
        end
        // clock enable falling: choose entry
        if (cke_prev_r && !cke_now) begin
          if (cmd_nxt == ddc_pkg::DDC_CMD_REF && all_idle) begin
            cmd_nxt = ddc_pkg::DDC_CMD_SREF;
            pwr_nxt = ddc_pkg::DDC_PS_SREF;
          end else if (cmd_nxt == ddc_pkg::DDC_CMD_NOP) begin
            cmd_nxt = ddc_pkg::DDC_CMD_PDE;
            pwr_nxt = all_idle ? ddc_pkg::DDC_PS_PPD : ddc_pkg::DDC_PS_APD;
          end else begin
            cmd_nxt = ddc_pkg::DDC_CMD_NOP;
          end
        end
      end
      // power-down: leave only on no-op or deselect with enable high
      ddc_pkg::DDC_PS_PPD, ddc_pkg::DDC_PS_APD: begin
        if (cke_now && (cs_n || enc == ddc_pkg::ENC_NOP)) begin
          cmd_nxt = ddc_pkg::DDC_CMD_PDX;
          pwr_nxt = ddc_pkg::DDC_PS_RUN;
        end
      end
      // self refresh: leave only on no-op or deselect with enable high
      ddc_pkg::DDC_PS_SREF: begin
        if (cke_now && (cs_n || enc == ddc_pkg::ENC_NOP)) begin
          cmd_nxt = ddc_pkg::DDC_CMD_SRX;
          pwr_nxt = ddc_pkg::DDC_PS_RUN;
        end
      end
      default: pwr_nxt = ddc_pkg::DDC_PS_RUN;
    endcase
  end

  // power state and clock enable history, updated per link edge
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      pwr_r <= ddc_pkg::DDC_PS_RUN;
      cke_prev_r <= 1'b0;
    end else if (link_rise) begin
      pwr_r <= pwr_nxt;
      cke_prev_r <= cke_now;
    end
  end

  // decoded command outputs, one-cycle valid pulse
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      cmd_valid_o <= 1'b0;
      cmd_o <= ddc_pkg::DDC_CMD_NOP;
      cmd_bank_o <= '0;
      row_o <= '0;
      col_o <= '0;
      auto_pre_o <= 1'b0;
    end else begin
      cmd_valid_o <= link_rise;
      if (link_rise) begin
        cmd_o <= cmd_nxt;
        cmd_bank_o <= bank_s;
        row_o <= (cmd_nxt == ddc_pkg::DDC_CMD_ACT) ? addr_s : '0;
        col_o <= (cmd_nxt == ddc_pkg::DDC_CMD_RD || cmd_nxt == ddc_pkg::DDC_CMD_WR)
                 ? col_of(addr_s) : '0;
        auto_pre_o <= (cmd_nxt == ddc_pkg::DDC_CMD_RD || cmd_nxt == ddc_pkg::DDC_CMD_WR)
                      & ap_bit;
      end
    end
  end

  // mode registers
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      mode_reg_o <= '0;
      ext_mode_reg_o <= '0;
    end else if (link_rise) begin
      if (cmd_nxt == ddc_pkg::DDC_CMD_MRS) begin
        mode_reg_o <= addr_s;
      end else if (cmd_nxt == ddc_pkg::DDC_CMD_EMRS) begin
        ext_mode_reg_o <= addr_s;
      end
    end
  end

  // open-row tracking per bank, incl. auto-precharge at the read or write command edge
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      bank_open_o <= '0;
    end else if (link_rise) begin
      case (cmd_nxt)
        ddc_pkg::DDC_CMD_ACT: bank_open_o[bank_s] <= 1'b1;
        ddc_pkg::DDC_CMD_PRE: bank_open_o[bank_s] <= 1'b0;
        ddc_pkg::DDC_CMD_PREALL: bank_open_o <= '0;
        ddc_pkg::DDC_CMD_RD, ddc_pkg::DDC_CMD_WR: begin
          if (ap_bit) begin
            bank_open_o[bank_s] <= 1'b0;
          end
        end
        default: bank_open_o <= bank_open_o;
      endcase
    end
  end

  // burst tracker, in link clock edges
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      burst_cnt_r <= '0;
      burst_wr_r <= 1'b0;
    end else if (link_rise) begin
      if (cmd_nxt == ddc_pkg::DDC_CMD_RD || cmd_nxt == ddc_pkg::DDC_CMD_WR) begin
        burst_cnt_r <= BC_W'(BURST_CYC);
        burst_wr_r <= (cmd_nxt == ddc_pkg::DDC_CMD_WR);
      end else if (cmd_nxt == ddc_pkg::DDC_CMD_BST && !burst_wr_r) begin
        burst_cnt_r <= '0;
      end else if (burst_cnt_r != '0) begin
        burst_cnt_r <= burst_cnt_r - BC_W'(1);
      end
    end
  end

  // refresh counters advance on each refresh, pins ignored
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ref_bank_o <= '0;
      ref_row_o <= '0;
    end else if (link_rise &&
                 (cmd_nxt == ddc_pkg::DDC_CMD_REF || cmd_nxt == ddc_pkg::DDC_CMD_SREF)) begin
      {ref_row_o, ref_bank_o} <= {ref_row_o, ref_bank_o} + 15'h1;
    end
  end

  // self-refresh exit hold-off, in system clock cycles
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      exit_cnt_r <= '0;
    end else if (link_rise && cmd_nxt == ddc_pkg::DDC_CMD_SRX) begin
      exit_cnt_r <= EX_W'(ddc_pkg::SELF_REFRESH_EXIT_CYC);
    end else if (exit_cnt_r != '0) begin
      exit_cnt_r <= exit_cnt_r - EX_W'(1);
    end
  end

  // status outputs
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      pwr_state_o <= ddc_pkg::DDC_PS_RUN;
      exit_busy_o <= 1'b0;
    end else begin
      pwr_state_o <= pwr_r;
      exit_busy_o <= (exit_cnt_r != '0);
    end
  end

  // lane masks and strobe direction
  ddc_lane_mask #(.LANES(LANES)) u_lanes (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .wr_phase_i((burst_cnt_r != '0) && burst_wr_r),
    .rd_phase_i((burst_cnt_r != '0) && !burst_wr_r),
    .mask_i(mask_s),
    .byte_we_o(byte_we_o),
    .strobe_oe_n_o(strobe_oe_n_o)
  );

endmodule : ddc_decoder

/* File: ddc_pkg.sv */
// shared constants and types for the ddr command and clock-enable decoder
package ddc_pkg;

  // bus widths
  localparam int ADDR_W = 13;
  localparam int BANK_W = 2;
  localparam int NUM_BANKS = 4;

  // auto-precharge bit position per data width
  localparam int AP_BIT_X32 = 8;
  localparam int AP_BIT_X16 = 10;
  localparam int AP_BIT_X8 = 10;

  // column-address extra bits for the x8 and x32 parts
  localparam int COL_HI_X8 = 11;
  localparam int COL_A9 = 9;

  // bank select codes for mode register load
  localparam logic [1:0] MR_BASE_SEL = 2'h0;

  // data width selector codes
  localparam logic [1:0] WIDTH_X8 = 2'h0;
  localparam logic [1:0] WIDTH_X16 = 2'h1;
  localparam logic [1:0] WIDTH_X32 = 2'h2;

  // command codes {ras_n, cas_n, we_n} with chip select low
  localparam logic [2:0] ENC_NOP = 3'h7;
  localparam logic [2:0] ENC_ACT = 3'h3;
  localparam logic [2:0] ENC_RD = 3'h5;
  localparam logic [2:0] ENC_WR = 3'h4;
  localparam logic [2:0] ENC_BST = 3'h6;
  localparam logic [2:0] ENC_PRE = 3'h2;
  localparam logic [2:0] ENC_REF = 3'h1;
  localparam logic [2:0] ENC_MRS = 3'h0;

  // self-refresh exit delay in ns and derived cycles at 100 MHz
  localparam int CLK_PERIOD_NS = 10;
  localparam int SELF_REFRESH_EXIT_DELAY_NS = 80;
  localparam int SELF_REFRESH_EXIT_CYC =
    (SELF_REFRESH_EXIT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // decoded command kinds
  typedef enum logic [3:0] {
    DDC_CMD_NOP = 4'h0,
    DDC_CMD_ACT = 4'h1,
    DDC_CMD_RD = 4'h2,
    DDC_CMD_WR = 4'h3,
    DDC_CMD_BST = 4'h4,
    DDC_CMD_PRE = 4'h5,
    DDC_CMD_PREALL = 4'h6,
    DDC_CMD_REF = 4'h7,
    DDC_CMD_MRS = 4'h8,
    DDC_CMD_EMRS = 4'h9,
    DDC_CMD_SREF = 4'ha,
    DDC_CMD_PDE = 4'hb,
    DDC_CMD_PDX = 4'hc,
    DDC_CMD_SRX = 4'hd
  } ddc_cmd_e;

  // power states, one-hot
  typedef enum logic [3:0] {
    DDC_PS_RUN = 4'h1,
    DDC_PS_PPD = 4'h2,
    DDC_PS_APD = 4'h4,
    DDC_PS_SREF = 4'h8
  } ddc_pwr_e;

endpackage : ddc_pkg

/* File: ddc_sync.sv */
// three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/10ps
module ddc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // raw and filtered level
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  // stage registers; s1_r feeds only s2_r
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // shift chain
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      s1_r <= INIT;
      s2_r <= INIT;
      s3_r <= INIT;
    end else begin
      s1_r <= d_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // accept a change once stages two and three agree
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      q_o <= INIT;
    end else if (s2_r == s3_r) begin
      q_o <= s3_r;
    end
  end

endmodule : ddc_sync

/* File: ddc_lane_mask.sv */
// per-byte write-enable and strobe direction for the data lanes
`timescale 1ns/10ps
module ddc_lane_mask #(
  parameter int LANES = 2
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // burst phase from the decoder
  input wire logic wr_phase_i,
  input wire logic rd_phase_i,
  // sampled lane masks, high inhibits the byte
  input wire logic [LANES-1:0] mask_i,
  // byte write enables and strobe output enables (low drives)
  output logic [LANES-1:0] byte_we_o,
  output logic [LANES-1:0] strobe_oe_n_o
);

  // a byte is written only in write phase with its mask low
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      byte_we_o <= '0;
    end else begin
      byte_we_o <= wr_phase_i ? ~mask_i : '0;
    end
  end

  // strobes driven by the device during reads, received otherwise
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      strobe_oe_n_o <= '1;
    end else begin
      strobe_oe_n_o <= rd_phase_i ? '0 : '1;
    end
  end

endmodule : ddc_lane_mask

/* File: ddc_decoder_asserts.sv */
// port assertions for the ddr command decoder
`timescale 1ns/10ps
module ddc_decoder_asserts #(
  parameter int LANES = 2
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // decoded command
  input wire logic cmd_valid_o,
  input wire logic [3:0] cmd_o,
  input wire logic [1:0] cmd_bank_o,
  input wire logic [12:0] row_o,
  input wire logic auto_pre_o,
  // status and lanes
  input wire logic [3:0] bank_open_o,
  input wire logic [3:0] pwr_state_o,
  input wire logic exit_busy_o,
  input wire logic [LANES-1:0] byte_we_o,
  input wire logic [LANES-1:0] strobe_oe_n_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);
  // one decoded command of a given kind
  sequence cmd_s(logic [3:0] k);
    cmd_valid_o && cmd_o == k;
  endsequence
  // exit wait window after self refresh
  sequence busy_s;
    exit_busy_o [*8] ##1 !exit_busy_o;
  endsequence
  AST_VALID_PULSE: assert property (cmd_valid_o |=> !cmd_valid_o)
    else $error("command valid wider than one cycle");
  AST_FIELDS_HOLD: assert property (!cmd_valid_o |-> $stable(cmd_o) && $stable(cmd_bank_o))
    else $error("command fields moved between edges");
  AST_ROW_ACT_ONLY: assert property (cmd_valid_o && cmd_o != ddc_pkg::DDC_CMD_ACT |-> row_o == 13'h0)
    else $error("row shown outside activate");
  AST_ACT_OPENS: assert property (cmd_s(ddc_pkg::DDC_CMD_ACT) |-> bank_open_o[cmd_bank_o])
    else $error("activate left bank closed");
  AST_AP_RW_ONLY: assert property (cmd_valid_o && !(cmd_o inside {ddc_pkg::DDC_CMD_RD,
    ddc_pkg::DDC_CMD_WR}) |-> !auto_pre_o)
    else $error("auto precharge outside read or write");
  AST_PREALL_CLOSES: assert property (cmd_s(ddc_pkg::DDC_CMD_PREALL) |-> bank_open_o == 4'h0)
    else $error("precharge all left a bank open");
  // the power state port lags the command strobe by one cycle
  AST_PDE_KIND: assert property (cmd_s(ddc_pkg::DDC_CMD_PDE) |=> pwr_state_o ==
    (bank_open_o == 4'h0 ? ddc_pkg::DDC_PS_PPD : ddc_pkg::DDC_PS_APD))
    else $error("wrong power-down kind");
  AST_SREF_STATE: assert property (cmd_s(ddc_pkg::DDC_CMD_SREF) |=>
    pwr_state_o == ddc_pkg::DDC_PS_SREF && bank_open_o == 4'h0)
    else $error("self refresh entry state wrong");
  AST_PWR_ONEHOT: assert property ($onehot(pwr_state_o))
    else $error("power state not one-hot");
  AST_EXIT_WAIT: assert property ($rose(exit_busy_o) |-> busy_s)
    else $error("exit wait length wrong");
  AST_STROBE_DIR: assert property (|byte_we_o |-> &strobe_oe_n_o)
    else $error("strobe driven during write");
endmodule : ddc_decoder_asserts

/* File: ddc_ctrl_model.sv */
// controller model framing one command per link clock pulse
`timescale 1ns/10ps
module ddc_ctrl_model (
  // clock and request
  input wire logic clock_i,
  input wire logic go_i,
  input wire logic [19:0] cmd_i,
  // command pins and status
  output logic link_clk_o,
  output logic [19:0] pins_o,
  output logic idle_o
);
  logic [4:0] cnt_r = 5'h0; // frame phase, zero when idle
  logic link_r = 1'b0; // link clock, still outside frames
  logic [19:0] pin_r = 20'h7c000; // cke low, deselected
  assign link_clk_o = link_r;
  assign pins_o = pin_r;
  assign idle_o = (cnt_r == 5'h0);
  // pins settle 7 clocks, link high 8 clocks, then release
  always_ff @(posedge clock_i) begin
    link_r <= (cnt_r >= 5'h7) && (cnt_r < 5'hf);
    if (cnt_r == 5'h0 && go_i) begin
      cnt_r <= 5'h1;
      pin_r <= cmd_i;
    end else if (cnt_r == 5'h10) begin
      cnt_r <= 5'h0;
      pin_r[18] <= 1'b1; // deselect, cke kept
      pin_r[17:0] <= ~pin_r[17:0];
    end else if (cnt_r != 5'h0) begin
      cnt_r <= cnt_r + 5'h1;
    end
  end
endmodule : ddc_ctrl_model

/* File: tb_ddc_decoder.sv */
// self-checking bench for the ddr command decoder
`timescale 1ns/10ps
module tb_ddc_decoder;
  logic clock_i = 1'b0; // system clock
  logic srst_i = 1'b1; // sync reset
  logic go_r = 1'b0; // frame request
  logic [19:0] cmd_r = 20'h7c000; // cke, cs_n, ras/cas/we, bank, addr
  logic [1:0] mask_r = 2'h0; // lane masks
  logic link_clk, idle, cmd_valid, auto_pre, exit_busy;
  logic [19:0] pins;
  logic [3:0] cmd, bank_open, pwr_state;
  logic [1:0] cmd_bank, ref_bank, byte_we, strobe_oe_n;
  logic [12:0] row, col, mode_reg, ext_mode_reg, ref_row;
  int err_count = 0;
  int compares = 0;
  int cycles = 0;
  ddc_ctrl_model u_ctrl (.clock_i(clock_i), .go_i(go_r), .cmd_i(cmd_r),
    .link_clk_o(link_clk), .pins_o(pins), .idle_o(idle));
  ddc_decoder uut (.clock_i(clock_i), .srst_i(srst_i), .link_clk_i(link_clk),
    .clk_en_i(pins[19]), .chip_sel_n_i(pins[18]), .row_strobe_n_i(pins[17]),
    .col_strobe_n_i(pins[16]), .write_en_n_i(pins[15]), .bank_i(pins[14:13]),
    .addr_i(pins[12:0]), .byte_mask_i(mask_r), .cmd_valid_o(cmd_valid), .cmd_o(cmd),
    .cmd_bank_o(cmd_bank), .row_o(row), .col_o(col), .auto_pre_o(auto_pre),
    .mode_reg_o(mode_reg), .ext_mode_reg_o(ext_mode_reg), .bank_open_o(bank_open),
    .pwr_state_o(pwr_state), .exit_busy_o(exit_busy), .ref_bank_o(ref_bank),
    .ref_row_o(ref_row), .byte_we_o(byte_we), .strobe_oe_n_o(strobe_oe_n));
  initial begin
    forever #5 clock_i = ~clock_i;
  end
  // cycle ceiling against hangs
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_count++;
      final_report();
    end
  end
  task automatic final_report;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [12:0] e, input logic [12:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one framed command, wait for its decode and the frame end
  task automatic iss(input logic [19:0] c, input logic [3:0] x);
    int n;
    n = 0;
    @(posedge clock_i);
    go_r <= 1'b1;
    cmd_r <= c;
    @(posedge clock_i);
    go_r <= 1'b0;
    @(negedge clock_i);
    while (cmd_valid !== 1'b1 && n < 40) begin
      @(negedge clock_i);
      n++;
    end
    chk("valid", 13'h1, 13'(cmd_valid));
    chk("cmd", 13'(x), 13'(cmd));
    while (idle !== 1'b1 && n < 80) begin
      @(negedge clock_i);
      n++;
    end
  endtask : iss
  initial begin
    repeat (6) @(posedge clock_i);
    srst_i <= 1'b0;
    @(negedge clock_i);
    chk("pwr", 13'(ddc_pkg::DDC_PS_RUN), 13'(pwr_state));
    chk("oe_n", 13'h3, 13'(strobe_oe_n));
    iss({2'b10, ddc_pkg::ENC_MRS, ddc_pkg::MR_BASE_SEL, 13'h0123}, ddc_pkg::DDC_CMD_MRS);
    iss({2'b10, ddc_pkg::ENC_MRS, 2'h1, 13'h00a5}, ddc_pkg::DDC_CMD_EMRS);
    chk("ext", 13'h00a5, ext_mode_reg);
    chk("mode", 13'h0123, mode_reg);
    iss({2'b11, ddc_pkg::ENC_ACT, 2'h2, 13'h1abc}, ddc_pkg::DDC_CMD_NOP);
    iss({2'b10, ddc_pkg::ENC_NOP, 2'h2, 13'h1abc}, ddc_pkg::DDC_CMD_NOP);
    chk("open", 13'h0, 13'(bank_open));
    iss({2'b10, ddc_pkg::ENC_ACT, 2'h2, 13'h1abc}, ddc_pkg::DDC_CMD_ACT);
    chk("row", 13'h1abc, row);
    chk("bank", 13'h2, 13'(cmd_bank));
    chk("open", 13'h4, 13'(bank_open));
    iss({2'b10, ddc_pkg::ENC_RD, 2'h2, 13'h1bff}, ddc_pkg::DDC_CMD_RD);
    chk("col", 13'h03ff, col);
    chk("ap", 13'h0, 13'(auto_pre));
    chk("oe_n", 13'h0, 13'(strobe_oe_n));
    iss({2'b10, ddc_pkg::ENC_BST, 2'h0, 13'h0}, ddc_pkg::DDC_CMD_BST);
    chk("oe_n", 13'h3, 13'(strobe_oe_n));
    @(posedge clock_i);
    mask_r <= 2'h1;
    iss({2'b10, ddc_pkg::ENC_WR, 2'h2, 13'h0555}, ddc_pkg::DDC_CMD_WR);
    chk("col", 13'h0155, col);
    chk("ap", 13'h1, 13'(auto_pre));
    chk("we", 13'h2, 13'(byte_we));
    chk("open", 13'h0, 13'(bank_open));
    iss({2'b10, ddc_pkg::ENC_ACT, 2'h1, 13'h0}, ddc_pkg::DDC_CMD_ACT);
    iss({2'b10, ddc_pkg::ENC_ACT, 2'h3, 13'h0}, ddc_pkg::DDC_CMD_ACT);
    iss({2'b10, ddc_pkg::ENC_PRE, 2'h1, 13'h0}, ddc_pkg::DDC_CMD_PRE);
    chk("open", 13'h8, 13'(bank_open));
    iss({2'b10, ddc_pkg::ENC_PRE, 2'h1, 13'h0400}, ddc_pkg::DDC_CMD_PREALL);
    iss({2'b10, ddc_pkg::ENC_REF, 2'h3, 13'h1fff}, ddc_pkg::DDC_CMD_REF);
    chk("rbank", 13'h1, 13'(ref_bank));
    chk("rrow", 13'h0, ref_row);
    iss({2'b10, ddc_pkg::ENC_ACT, 2'h0, 13'h0}, ddc_pkg::DDC_CMD_ACT);
    iss({2'b00, ddc_pkg::ENC_NOP, 2'h0, 13'h0}, ddc_pkg::DDC_CMD_PDE);
    chk("pwr", 13'(ddc_pkg::DDC_PS_APD), 13'(pwr_state));
    iss({2'b00, ddc_pkg::ENC_ACT, 2'h2, 13'h0}, ddc_pkg::DDC_CMD_NOP);
    chk("open", 13'h1, 13'(bank_open));
    iss({2'b11, ddc_pkg::ENC_NOP, 2'h0, 13'h0}, ddc_pkg::DDC_CMD_PDX);
    chk("pwr", 13'(ddc_pkg::DDC_PS_RUN), 13'(pwr_state));
    iss({2'b10, ddc_pkg::ENC_PRE, 2'h0, 13'h0}, ddc_pkg::DDC_CMD_PRE);
    iss({2'b00, ddc_pkg::ENC_NOP, 2'h0, 13'h0}, ddc_pkg::DDC_CMD_PDE);
    chk("pwr", 13'(ddc_pkg::DDC_PS_PPD), 13'(pwr_state));
    iss({2'b10, ddc_pkg::ENC_NOP, 2'h0, 13'h0}, ddc_pkg::DDC_CMD_PDX);
    iss({2'b00, ddc_pkg::ENC_REF, 2'h1, 13'h0}, ddc_pkg::DDC_CMD_SREF);
    chk("pwr", 13'(ddc_pkg::DDC_PS_SREF), 13'(pwr_state));
    chk("rbank", 13'h2, 13'(ref_bank));
    iss({2'b00, ddc_pkg::ENC_ACT, 2'h2, 13'h0}, ddc_pkg::DDC_CMD_NOP);
    chk("open", 13'h0, 13'(bank_open));
    iss({2'b10, ddc_pkg::ENC_NOP, 2'h0, 13'h0}, ddc_pkg::DDC_CMD_SRX);
    chk("pwr", 13'(ddc_pkg::DDC_PS_RUN), 13'(pwr_state));
    chk("busy", 13'h1, 13'(exit_busy));
    repeat (ddc_pkg::SELF_REFRESH_EXIT_CYC) @(negedge clock_i);
    chk("busy", 13'h0, 13'(exit_busy));
    final_report();
  end
endmodule : tb_ddc_decoder
bind ddc_decoder ddc_decoder_asserts #(.LANES(LANES)) u_ast (.clock_i(clock_i),
  .srst_i(srst_i), .cmd_valid_o(cmd_valid_o), .cmd_o(cmd_o), .cmd_bank_o(cmd_bank_o),
  .row_o(row_o), .auto_pre_o(auto_pre_o), .bank_open_o(bank_open_o),
  .pwr_state_o(pwr_state_o), .exit_busy_o(exit_busy_o), .byte_we_o(byte_we_o),
  .strobe_oe_n_o(strobe_oe_n_o));
